// >>> core/flash_cmd_host.sv
// Host controller that issues command sequences to a banked NOR flash
// Assumes a synchronous software port and flash pins sampled on sys_clk_i
// Rules of the flash device, tagged [RLn] where the code handles them
// RL1: Array reads need no preceding command writes
// RL2: Write F0 to leave autoselect or reset
// RL3: Unlock AA to 555, 55 to 2AA
// RL4: Autoselect is 90 to bank 555
// RL5: Read ID at offsets 01, 0E, 0F
// RL6: Offset 03 gives secured sector lock bits
// RL7: Offset 02 gives sector group protection
// RL8: Program address set before write strobe falls
// RL9: Program word held through strobe rise
// RL10: Erase is six writes, 10 or 30
// RL11: B0 to bank suspends a sector erase
// RL12: 30 to bank resumes suspended erase
// RL13: Bank chosen by address bits from A19
// RL14: 98 to 55 enters query table
// RL15: Bypass ops only after bypass entry
// RL16: Bypass program and erase take two writes
// RL17: Bypass exit is 90 then 00
// RL18: Accelerated program needs elevated pin voltage
// RL19: Mismatched cycle aborts sequence to array read
`default_nettype none
module flash_cmd_host (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [15:0] reg_rdata_o,
    output logic             irq_o,
    output logic      [22:0] flash_addr_o,
    output logic      [15:0] flash_dq_o,
    output logic             flash_dq_oe_o,
    input  wire logic [15:0] flash_dq_i,
    output logic             chip_select_n_o,
    output logic             write_strobe_n_o,
    output logic             read_strobe_n_o,
    output logic             write_protect_accel_pin_o
);
    // ------------------------------------------------------------------
    // Types and helpers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_PULSE = 3'b010,
        ST_HOLD  = 3'b011,
        ST_READ  = 3'b100
    } phase_type;

    typedef struct packed {
        logic        is_read;
        logic [22:0] addr;
        logic [15:0] data;
    } cycle_type;

    // Bank bits from the target, low bits from the command address
    function automatic logic [22:0] bank_addr(input logic [22:0] target,
                                              input logic [11:0] low);
        bank_addr = {target[22:flash_cmd_pkg::BANK_LSB], 7'h00, low};
    endfunction

    function automatic cycle_type wr(input logic [22:0] a, input logic [7:0] d);
        wr = '{is_read: 1'b0, addr: a, data: {8'h00, d}};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    phase_type   phase, next_phase;
    logic [3:0]  op, next_op;
    logic [2:0]  step, next_step;
    logic [2:0]  total, next_total;
    logic [4:0]  timer, next_timer;
    logic [22:0] target, next_target;
    logic [15:0] wdata, next_wdata;
    logic [15:0] rdata, next_rdata;
    logic [15:0] id1, next_id1;
    logic [15:0] id2, next_id2;
    logic [15:0] id3, next_id3;
    logic [1:0]  irq_stat, next_irq_stat;
    logic [1:0]  irq_mask, next_irq_mask;
    logic        bypass, next_bypass;
    logic        suspended, next_suspended;
    logic        erasing, next_erasing;
    logic        accel, next_accel;
    logic [15:0] rd_out, next_rd_out;
    logic [22:0] pin_addr, next_pin_addr;
    logic [15:0] pin_dq, next_pin_dq;
    logic        pin_oe, next_pin_oe;
    logic        pin_cs_n, next_pin_cs_n;
    logic        pin_we_n, next_pin_we_n;
    logic        pin_oe_n, next_pin_oe_n;
    logic        irq, next_irq;
    cycle_type   cyc;
    logic        done_ev, bad_ev;

    // ------------------------------------------------------------------
    // Sequence table: the cycle for each op and step
    // ------------------------------------------------------------------
    always_comb begin
        logic [22:0] u1;
        logic [22:0] u2;
        logic [22:0] ba;
        u1 = {11'h000, flash_cmd_pkg::UNLOCK_ADDR1};
        u2 = {11'h000, flash_cmd_pkg::UNLOCK_ADDR2};
        ba = bank_addr(target, flash_cmd_pkg::UNLOCK_ADDR1);  // [RL13]
        cyc = '{is_read: 1'b1, addr: target, data: 16'h0000};  // [RL1]
        if (step == 3'd0 && op != flash_cmd_pkg::OP_READ && !bypass
                && op != flash_cmd_pkg::OP_ACC_PROG) begin
            cyc = wr(u1, flash_cmd_pkg::UNLOCK_DATA1);  // [RL3]
        end else if (step == 3'd1 && !bypass && op != flash_cmd_pkg::OP_ACC_PROG
                && op != flash_cmd_pkg::OP_READ) begin
            cyc = wr(u2, flash_cmd_pkg::UNLOCK_DATA2);  // [RL3]
        end
        unique case (op)
            flash_cmd_pkg::OP_RESET: cyc = wr(target, flash_cmd_pkg::CMD_RESET);  // [RL2]
            flash_cmd_pkg::OP_SUSPEND: begin
                cyc = wr(target, flash_cmd_pkg::CMD_SUSPEND);  // [RL11]
            end
            flash_cmd_pkg::OP_RESUME: begin
                cyc = wr(target, flash_cmd_pkg::CMD_RESUME);  // [RL12]
            end
            flash_cmd_pkg::OP_QUERY: begin
                cyc = wr({11'h000, flash_cmd_pkg::QUERY_ADDR}, flash_cmd_pkg::CMD_QUERY);  // [RL14]
            end
            flash_cmd_pkg::OP_AUTOSEL, flash_cmd_pkg::OP_READ_ID,
            flash_cmd_pkg::OP_PROTECT, flash_cmd_pkg::OP_LOCK: begin
                if (step == 3'd2) cyc = wr(ba, flash_cmd_pkg::CMD_AUTOSEL);  // [RL4]
                if (step >= 3'd3) begin
                    cyc.is_read = 1'b1;
                    unique case (op)
                        flash_cmd_pkg::OP_READ_ID: begin
                            cyc.addr = bank_addr(target, step == 3'd3 ? flash_cmd_pkg::AS_ID1 :
                                step == 3'd4 ? flash_cmd_pkg::AS_ID2 : flash_cmd_pkg::AS_ID3);  // [RL5]
                        end
                        flash_cmd_pkg::OP_PROTECT: begin
                            cyc.addr = {target[22:flash_cmd_pkg::SECTOR_LSB],
                                        flash_cmd_pkg::AS_PROTECT[11:1], 1'b0};  // [RL7]
                        end
                        flash_cmd_pkg::OP_LOCK: cyc.addr = {11'h000, flash_cmd_pkg::AS_LOCK};  // [RL6]
                        default: cyc.addr = target;
                    endcase
                end
            end
            flash_cmd_pkg::OP_PROGRAM, flash_cmd_pkg::OP_ACC_PROG: begin
                if (step == total - 3'd2) cyc = wr(u1, flash_cmd_pkg::CMD_PROGRAM);  // [RL16]
                if (step == total - 3'd1) begin
                    cyc = '{is_read: 1'b0, addr: target, data: wdata};  // [RL8] [RL9]
                end
            end
            flash_cmd_pkg::OP_CHIP_ERASE, flash_cmd_pkg::OP_SECT_ERASE: begin
                if (bypass) begin
                    cyc = wr(u1, step == 3'd0 ? flash_cmd_pkg::CMD_ERASE :
                             flash_cmd_pkg::CMD_CHIP_ERASE);  // [RL16]
                end else begin
                    unique case (step)
                        3'd2: cyc = wr(u1, flash_cmd_pkg::CMD_ERASE);  // [RL10]
                        3'd3: cyc = wr(u1, flash_cmd_pkg::UNLOCK_DATA1);
                        3'd4: cyc = wr(u2, flash_cmd_pkg::UNLOCK_DATA2);
                        3'd5: begin
                            cyc = (op == flash_cmd_pkg::OP_CHIP_ERASE) ?
                                  wr(u1, flash_cmd_pkg::CMD_CHIP_ERASE) :
                                  wr(target, flash_cmd_pkg::CMD_SECT_ERASE);  // [RL10]
                        end
                        default: ;
                    endcase
                end
            end
            flash_cmd_pkg::OP_BYP_ENTER: begin
                if (step == 3'd2) cyc = wr(u1, flash_cmd_pkg::CMD_BYPASS);  // [RL15]
            end
            flash_cmd_pkg::OP_BYP_EXIT: begin
                cyc = wr(target, step == 3'd0 ? flash_cmd_pkg::CMD_AUTOSEL :
                         flash_cmd_pkg::CMD_BYPASS_EXIT);  // [RL17]
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0] len;
        logic       legal;
        next_phase = phase;
        next_op = op;
        next_step = step;
        next_total = total;
        next_timer = timer;
        next_target = target;
        next_wdata = wdata;
        next_rdata = rdata;
        next_id1 = id1;
        next_id2 = id2;
        next_id3 = id3;
        next_irq_mask = irq_mask;
        next_bypass = bypass;
        next_suspended = suspended;
        next_erasing = erasing;
        next_accel = accel;
        next_pin_addr = pin_addr;
        next_pin_dq = pin_dq;
        next_pin_oe = 1'b0;
        next_pin_cs_n = 1'b1;
        next_pin_we_n = 1'b1;
        next_pin_oe_n = 1'b1;
        next_rd_out = 16'h0000;
        done_ev = 1'b0;
        bad_ev = 1'b0;
        len = 3'd1;
        legal = 1'b1;
        unique case (reg_wdata_i[3:0])
            flash_cmd_pkg::OP_READ, flash_cmd_pkg::OP_RESET, flash_cmd_pkg::OP_QUERY: ;
            flash_cmd_pkg::OP_SUSPEND: begin
                legal = erasing && !suspended;  // [RL11]
            end
            flash_cmd_pkg::OP_RESUME: begin
                legal = suspended;  // [RL12]
            end
            flash_cmd_pkg::OP_AUTOSEL, flash_cmd_pkg::OP_BYP_ENTER: begin
                len = 3'd3;
                legal = !bypass;
            end
            flash_cmd_pkg::OP_PROTECT, flash_cmd_pkg::OP_LOCK: len = 3'd4;
            flash_cmd_pkg::OP_READ_ID: len = 3'd6;  // [RL5]
            flash_cmd_pkg::OP_PROGRAM: len = bypass ? 3'd2 : 3'd4;  // [RL16]
            flash_cmd_pkg::OP_ACC_PROG: len = 3'd2;  // [RL18]
            flash_cmd_pkg::OP_CHIP_ERASE: len = bypass ? 3'd2 : 3'd6;
            flash_cmd_pkg::OP_SECT_ERASE: begin
                len = 3'd6;
                legal = !bypass;
            end
            flash_cmd_pkg::OP_BYP_EXIT: begin
                len = 3'd2;
                legal = bypass;  // [RL15]
            end
            default: legal = 1'b0;
        endcase
        if (reg_write_i) begin
            unique case (reg_addr_i)
                flash_cmd_pkg::REG_ADDR: next_target[15:0] = reg_wdata_i;
                flash_cmd_pkg::REG_ADDR_HI: next_target[22:16] = reg_wdata_i[6:0];
                flash_cmd_pkg::REG_DATA: next_wdata = reg_wdata_i;
                flash_cmd_pkg::REG_MASK: next_irq_mask = reg_wdata_i[1:0];
                flash_cmd_pkg::REG_CMD: begin
                    if (phase != ST_IDLE || !legal) begin
                        bad_ev = 1'b1;
                    end else begin
                        next_op = reg_wdata_i[3:0];
                        next_total = len;
                        next_step = 3'd0;
                        next_phase = ST_SETUP;
                        next_timer = 5'd0;
                    end
                end
                default: ;
            endcase
        end
        unique case (phase)
            ST_IDLE: ;
            ST_SETUP: begin
                next_pin_addr = cyc.addr;
                next_pin_dq = cyc.data;
                next_pin_oe = !cyc.is_read;
                next_pin_cs_n = 1'b0;
                next_accel = (op == flash_cmd_pkg::OP_ACC_PROG);  // [RL18]
                next_timer = 5'd0;
                next_phase = cyc.is_read ? ST_READ : ST_PULSE;
            end
            ST_PULSE: begin
                // Address settled before strobe falls, data held past its rise
                next_pin_oe = 1'b1;
                next_pin_cs_n = 1'b0;
                next_pin_we_n = 1'b0;
                next_timer = timer + 5'd1;
                if (timer == 5'(flash_cmd_pkg::STROBE_CYC - 1)) next_phase = ST_HOLD;
            end
            ST_HOLD: begin
                next_pin_oe = 1'b1;
                next_pin_cs_n = 1'b0;
                next_phase = ST_IDLE;
            end
            ST_READ: begin
                next_pin_cs_n = 1'b0;
                next_pin_oe_n = 1'b0;
                next_timer = timer + 5'd1;
                if (timer == 5'(flash_cmd_pkg::READ_CYC - 1)) begin
                    next_phase = ST_IDLE;
                    next_rdata = flash_dq_i;
                    if (op == flash_cmd_pkg::OP_READ_ID) begin
                        if (step == 3'd3) next_id1 = flash_dq_i;
                        if (step == 3'd4) next_id2 = flash_dq_i;
                        if (step == 3'd5) next_id3 = flash_dq_i;
                    end
                end
            end
            default: next_phase = ST_IDLE;
        endcase
        if ((phase == ST_HOLD || (phase == ST_READ && next_phase == ST_IDLE))) begin
            if (step + 3'd1 < total) begin
                next_step = step + 3'd1;
                next_phase = ST_SETUP;
            end else begin
                done_ev = 1'b1;
                next_accel = 1'b0;
                unique case (op)
                    flash_cmd_pkg::OP_BYP_ENTER: next_bypass = 1'b1;
                    flash_cmd_pkg::OP_BYP_EXIT: next_bypass = 1'b0;
                    flash_cmd_pkg::OP_SECT_ERASE: next_erasing = 1'b1;
                    flash_cmd_pkg::OP_SUSPEND: next_suspended = 1'b1;
                    flash_cmd_pkg::OP_RESUME: next_suspended = 1'b0;
                    flash_cmd_pkg::OP_RESET: begin
                        // Reset keeps a suspended erase suspended
                        next_erasing = suspended;
                    end
                    default: ;
                endcase
            end
        end
        if (reg_read_i) begin
            unique case (reg_addr_i)
                flash_cmd_pkg::REG_STATUS: begin
                    next_rd_out = {11'h000, erasing, suspended, bypass, accel, phase != ST_IDLE};
                end
                flash_cmd_pkg::REG_IRQ: next_rd_out = {14'h0000, irq_stat};
                flash_cmd_pkg::REG_MASK: next_rd_out = {14'h0000, irq_mask};
                flash_cmd_pkg::REG_ID1: next_rd_out = id1;
                flash_cmd_pkg::REG_ID2: next_rd_out = id2;
                flash_cmd_pkg::REG_ID3: next_rd_out = id3;
                flash_cmd_pkg::REG_RDATA: next_rd_out = rdata;
                flash_cmd_pkg::REG_ADDR: next_rd_out = target[15:0];
                flash_cmd_pkg::REG_DATA: next_rd_out = wdata;
                default: next_rd_out = 16'h0000;
            endcase
        end
        // Set wins over the read-clear
        next_irq_stat = (reg_read_i && reg_addr_i == flash_cmd_pkg::REG_IRQ) ? 2'b00 : irq_stat;
        next_irq_stat[flash_cmd_pkg::IRQ_DONE_POS] = next_irq_stat[flash_cmd_pkg::IRQ_DONE_POS]
                                                     | done_ev;
        next_irq_stat[flash_cmd_pkg::IRQ_BAD_POS] = next_irq_stat[flash_cmd_pkg::IRQ_BAD_POS]
                                                    | bad_ev;  // [RL19]
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= ST_IDLE;
            op <= 4'h0;
            step <= 3'd0;
            total <= 3'd0;
            timer <= 5'd0;
            target <= 23'h000000;
            wdata <= 16'h0000;
            rdata <= 16'h0000;
            id1 <= 16'h0000;
            id2 <= 16'h0000;
            id3 <= 16'h0000;
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
            bypass <= 1'b0;
            suspended <= 1'b0;
            erasing <= 1'b0;
            accel <= 1'b0;
            rd_out <= 16'h0000;
            pin_addr <= 23'h000000;
            pin_dq <= 16'h0000;
            pin_oe <= 1'b0;
            pin_cs_n <= 1'b1;
            pin_we_n <= 1'b1;
            pin_oe_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            phase <= next_phase;
            op <= next_op;
            step <= next_step;
            total <= next_total;
            timer <= next_timer;
            target <= next_target;
            wdata <= next_wdata;
            rdata <= next_rdata;
            id1 <= next_id1;
            id2 <= next_id2;
            id3 <= next_id3;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            bypass <= next_bypass;
            suspended <= next_suspended;
            erasing <= next_erasing;
            accel <= next_accel;
            rd_out <= next_rd_out;
            pin_addr <= next_pin_addr;
            pin_dq <= next_pin_dq;
            pin_oe <= next_pin_oe;
            pin_cs_n <= next_pin_cs_n;
            pin_we_n <= next_pin_we_n;
            pin_oe_n <= next_pin_oe_n;
            irq <= next_irq;
        end
    end

    assign reg_rdata_o = rd_out;
    assign irq_o = irq;
    assign flash_addr_o = pin_addr;
    assign flash_dq_o = pin_dq;
    assign flash_dq_oe_o = pin_oe;
    assign chip_select_n_o = pin_cs_n;
    assign write_strobe_n_o = pin_we_n;
    assign read_strobe_n_o = pin_oe_n;
    assign write_protect_accel_pin_o = accel;
endmodule
`default_nettype wire

// >>> core/flash_cmd_pkg.sv
// Constants for the flash command host controller
// Assumes a 16-bit asynchronous NOR flash bus driven from a 200 MHz clock
package flash_cmd_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int BANK_LSB = 19;
    localparam int SECTOR_LSB = 12;
    // ------------------------------------------------------------------
    // Command addresses and codes
    // ------------------------------------------------------------------
    localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
    localparam logic [11:0] QUERY_ADDR = 12'h055;
    localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
    // ------------------------------------------------------------------
    // Autoselect offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] AS_ID1 = 12'h001;
    localparam logic [11:0] AS_ID2 = 12'h00e;
    localparam logic [11:0] AS_ID3 = 12'h00f;
    localparam logic [11:0] AS_PROTECT = 12'h002;
    localparam logic [11:0] AS_LOCK = 12'h003;
    localparam int FACTORY_LOCK_POS = 7;
    localparam int CUSTOMER_LOCK_POS = 6;
    // ------------------------------------------------------------------
    // Software registers of the controller
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_IRQ = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h5;
    localparam logic [3:0] REG_ID1 = 4'h6;
    localparam logic [3:0] REG_ID2 = 4'h7;
    localparam logic [3:0] REG_ID3 = 4'h8;
    localparam logic [3:0] REG_RDATA = 4'h9;
    localparam logic [3:0] REG_ADDR_HI = 4'ha;
    // Order codes written to the command register
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_RESET = 4'h1;
    localparam logic [3:0] OP_READ_ID = 4'h2;
    localparam logic [3:0] OP_PROTECT = 4'h3;
    localparam logic [3:0] OP_LOCK = 4'h4;
    localparam logic [3:0] OP_PROGRAM = 4'h5;
    localparam logic [3:0] OP_CHIP_ERASE = 4'h6;
    localparam logic [3:0] OP_SECT_ERASE = 4'h7;
    localparam logic [3:0] OP_SUSPEND = 4'h8;
    localparam logic [3:0] OP_RESUME = 4'h9;
    localparam logic [3:0] OP_QUERY = 4'ha;
    localparam logic [3:0] OP_BYP_ENTER = 4'hb;
    localparam logic [3:0] OP_BYP_EXIT = 4'hc;
    localparam logic [3:0] OP_ACC_PROG = 4'hd;
    localparam logic [3:0] OP_AUTOSEL = 4'he;
    localparam int IRQ_DONE_POS = 0;
    localparam int IRQ_BAD_POS = 1;
    // ------------------------------------------------------------------
    // Bus timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int STROBE_NS = 60;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_NS = 80;
    localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// >>> testbench/flash_cmd_host_checker.sv
// Checker of the flash pin sequencing of the command host
// Bound into flash_cmd_host; sees only its clock, reset and flash side output ports
`default_nettype none
module flash_cmd_host_checker (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [22:0] flash_addr_o,
    input wire logic [15:0] flash_dq_o,
    input wire logic        flash_dq_oe_o,
    input wire logic        chip_select_n_o,
    input wire logic        write_strobe_n_o,
    input wire logic        read_strobe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence we_l; !write_strobe_n_o; endsequence
    a_we_in_cs: assert property (we_l |-> !chip_select_n_o) else $error("we without cs");
    a_we_setup: assert property ($fell(write_strobe_n_o) |-> !$past(chip_select_n_o))
        else $error("no setup cycle");
    a_we_width: assert property ($fell(write_strobe_n_o) |-> we_l[*8] ##5 $rose(write_strobe_n_o))
        else $error("bad strobe width");
    a_we_stable: assert property (we_l |-> $stable(flash_addr_o) && $stable(flash_dq_o))
        else $error("bus moved in strobe");
    a_we_drive: assert property (we_l |-> flash_dq_oe_o) else $error("dq not driven");
    a_we_hold: assert property ($rose(write_strobe_n_o) |-> !chip_select_n_o)
        else $error("no hold cycle");
    a_rd_width: assert property ($fell(read_strobe_n_o) |-> ##16 $rose(read_strobe_n_o))
        else $error("bad read width");
    a_rd_free: assert property (!read_strobe_n_o |-> !chip_select_n_o && !flash_dq_oe_o)
        else $error("read contention");
endmodule
bind flash_cmd_host flash_cmd_host_checker i_chk (.*);
`default_nettype wire

// >>> testbench/flash_dev_model.sv
// Banked flash device model facing the host
// Assumes clean strobes from the host; no clock on this side
`default_nettype none
module flash_dev_model #(
    parameter logic [15:0] ID1 = 16'h1a2b, ID2 = 16'h3c4d, ID3 = 16'h5e6f // Arbitrary
) (
    input  wire logic [22:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        acc_i,
    output logic      [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [22:0]];
    logic [15:0] rd;
    logic [22:0] a;
    int          step = 0;
    bit          asel = 0;
    bit          byp = 0;
    wire [7:0]   c = wdata_i[7:0];
    always @(negedge we_n_i) a = addr_i;
    always @(posedge we_n_i) begin
        if (step == 3) mem[a] = wdata_i;
        if (c == 8'hf0 && step != 3) asel = 0;
        if (step == 5) byp = (c != 8'h00);
        if (step == 2 && c == 8'h90) asel = 1;
        if (step == 2 && c == 8'h20) byp = 1;
        if ((byp || acc_i) && step < 2 && c == 8'ha0) step = 3;
        else if (byp && step < 2 && c == 8'h90) step = 5;
        else if (step == 0 && a[11:0] == 12'h555 && c == 8'haa) step = 1;
        else if (step == 1 && a[11:0] == 12'h2aa && c == 8'h55) step = 2;
        else if (step == 2 && c == 8'ha0) step = 3;
        else step = 0;
    end
    always @* begin
        rd = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
        if (asel) rd = addr_i[3:0] == 4'h1 ? ID1 : addr_i[3:0] == 4'he ? ID2 :
            addr_i[3:0] == 4'hf ? ID3 : addr_i[3:0] == 4'h2 ? 16'h0001 : 16'h0080;
    end
    // Released bus shows the inverse so a late sample cannot pass
    assign rdata_o = (!cs_n_i && !oe_n_i) ? rd : ~rd;
endmodule
`default_nettype wire

// >>> testbench/flash_cmd_host_test.sv
// Bench of the flash command host with a device model
// Assumes the core package and design, the model and the bound checker
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module flash_cmd_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] W = 2'h0, R = 2'h1, O = 2'h2;
    logic sys_clk_i = 0, rst_n_i = 0, reg_write_i = 0, reg_read_i = 0, rd_d = 0, irq_o;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0, reg_rdata_o, flash_dq_o, flash_dq_i, w, x, e;
    logic [22:0] flash_addr_o, t;
    logic flash_dq_oe_o, chip_select_n_o, write_strobe_n_o, read_strobe_n_o;
    logic write_protect_accel_pin_o;
    logic [21:0] s [$];
    logic [15:0] exp_q [$];
    int errors = 0, samples_checked = 0, seed = 32'h721f78f5;
    flash_cmd_host i_dut (.*);
    flash_dev_model i_dev (.addr_i(flash_addr_o), .wdata_i(flash_dq_o), .cs_n_i(chip_select_n_o),
        .we_n_i(write_strobe_n_o), .oe_n_i(read_strobe_n_o),
        .acc_i(write_protect_accel_pin_o), .rdata_o(flash_dq_i));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            `CHK(reg_rdata_o, e)
        end
        rd_d <= reg_read_i;
    end
    task automatic bus(input logic k, input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= !k;
        reg_read_i <= k;
        @(posedge sys_clk_i);
        reg_write_i <= 1'b0;
        reg_read_i <= 1'b0;
    endtask
    task automatic op(input logic [3:0] c, input logic [15:0] d);
        bus(0, 4'h0, {12'h0, c});
        repeat (3000) if (!irq_o) @(posedge sys_clk_i);
        exp_q.push_back(d);
        bus(1, 4'h4, 16'h0);
        repeat (2) @(posedge sys_clk_i);
        $display("order %h done", c);
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        errors++;
        finish_test();
    end
    initial begin
        t = $random(seed);
        w = $random(seed);
        x = $random(seed);
        s = '{{R,4'h3,16'h0}, {R,4'h4,16'h0}, {W,4'h5,16'h3}, {O,4'hf,16'h2},
            {O,4'h8,16'h2}, {O,4'h9,16'h2},
            {O,4'hc,16'h2}, {W,4'h1,t[15:0]}, {W,4'ha,9'h0,t[22:16]},
            {W,4'h2,w}, {O,4'h5,16'h1}, {O,4'h0,16'h1}, {R,4'h9,w},
            {O,4'h2,16'h1}, {R,4'h6,i_dev.ID1}, {R,4'h7,i_dev.ID2},
            {R,4'h8,i_dev.ID3}, {O,4'h1,16'h1}, {O,4'h3,16'h1},
            {R,4'h9,16'h1}, {O,4'h1,16'h1}, {O,4'h4,16'h1}, {R,4'h9,16'h80},
            {O,4'h1,16'h1}, {O,4'hb,16'h1}, {W,4'h2,x},
            {O,4'h5,16'h1}, {O,4'hc,16'h1},
            {O,4'h0,16'h1}, {R,4'h9,x}, {W,4'h2,~w}, {O,4'hd,16'h1},
            {O,4'h0,16'h1}, {R,4'h9,~w}, {O,4'ha,16'h1}, {O,4'h1,16'h1},
            {O,4'h6,16'h1}, {O,4'h7,16'h1},
            {O,4'h8,16'h1}, {O,4'h9,16'h1},
            {O,4'he,16'h1}, {O,4'h1,16'h1}};
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        foreach (s[i]) begin
            if (s[i][21:20] == O) op(s[i][19:16], s[i][15:0]);
            else if (s[i][21:20] == R) exp_q.push_back(s[i][15:0]);
            if (s[i][21:20] != O) bus(s[i][20], s[i][19:16], s[i][15:0]);
        end
        repeat (4) @(posedge sys_clk_i);
        finish_test();
    end
endmodule
`default_nettype wire
